// >>> ioe_consts.svh
/*
 * Constants for the increment / OR / jump execution block: widths, bit
 * positions, reset values and fixed step values.
 * Assumes it is included by bare name from the package only.
 */
`ifndef IOE_CONSTS_SVH
`define IOE_CONSTS_SVH

// ============================================================
// widths
`define IOE_DATA_W    8
`define IOE_ADDR_W    7
`define IOE_PC_W      13
`define IOE_LIT_W     11
`define IOE_LATCH_W   5
`define IOE_FILE_DEPTH 128

// ============================================================
// field positions
`define IOE_LATCH_HI  4
`define IOE_LATCH_LO  3
`define IOE_BYTE_HI   7

// ============================================================
// reset values and steps
`define IOE_ACC_RST   8'h00
`define IOE_ZERO_RST  1'b0
`define IOE_PC_RST    13'h0000
`define IOE_PC_STEP   13'h0001
`define IOE_DATA_ONE  8'h01
`define IOE_DATA_NULL 8'h00

`endif

// >>> ioe_pkg.sv
/*
 * Types shared by the execution block and its result unit.
 * Assumes ioe_consts.svh is on the include path.
 */
`include "ioe_consts.svh"

package ioe_pkg;

    typedef logic [`IOE_DATA_W-1:0]  ioe_data_t;
    typedef logic [`IOE_ADDR_W-1:0]  ioe_addr_t;
    typedef logic [`IOE_PC_W-1:0]    ioe_pc_t;
    typedef logic [`IOE_LIT_W-1:0]   ioe_lit_t;
    typedef logic [`IOE_LATCH_W-1:0] ioe_latch_t;

    // ============================================================
    // operation select
    typedef enum logic [2:0] {
        IOE_OP_NULL_SLOT     = 3'h0,
        IOE_OP_INC_FILE      = 3'h1,
        IOE_OP_INC_SKIP_ZERO = 3'h2,
        IOE_OP_ABS_JUMP      = 3'h3,
        IOE_OP_OR_LITERAL    = 3'h4,
        IOE_OP_OR_FILE       = 3'h5
    } ioe_op_t;

    // ============================================================
    // sequencer states, one-hot
    typedef enum logic [2:0] {
        IOE_ST_READY = 3'b001,
        IOE_ST_JUMP  = 3'b010,
        IOE_ST_NULL  = 3'b100
    } ioe_state_t;

    function automatic logic ioe_is_zero(input ioe_data_t v);
        return (v == `IOE_DATA_NULL);
    endfunction

    function automatic logic ioe_uses_file(input ioe_op_t op);
        return (op == IOE_OP_INC_FILE) || (op == IOE_OP_INC_SKIP_ZERO) ||
               (op == IOE_OP_OR_FILE);
    endfunction

endpackage

// >>> ioe_alu_if.sv
/*
 * Carrier between the execution sequencer and its result unit.
 * Assumes both ends sit in one clock domain; all signals are combinational.
 */
`timescale 1ns/100ps
`default_nettype none

interface ioe_alu_if;
    import ioe_pkg::*;

    ioe_op_t   op;
    ioe_data_t acc;
    ioe_data_t operand;
    ioe_data_t literal;
    ioe_data_t result;
    logic      zero;

    modport core (output op, acc, operand, literal, input result, zero);
    modport alu  (input op, acc, operand, literal, output result, zero);
endinterface

`default_nettype wire

// >>> ioe_alu.sv
/*
 * Result unit: forms the 8-bit result and its zero indication.
 * Assumes the sequencer decides routing, flag update and skipping.
 */
`timescale 1ns/100ps
`default_nettype none

module ioe_alu
    import ioe_pkg::*;
(
    ioe_alu_if.alu bus
);

    // ============================================================
    // result
    always_comb begin
        case (bus.op)
            IOE_OP_INC_FILE,
            IOE_OP_INC_SKIP_ZERO: begin
                // wraps at 8 bits, so FFh gives zero
                bus.result = bus.operand + `IOE_DATA_ONE;
            end
            IOE_OP_OR_LITERAL: begin
                bus.result = bus.acc | bus.literal;
            end
            IOE_OP_OR_FILE: begin
                bus.result = bus.acc | bus.operand;
            end
            default: begin
                bus.result = `IOE_DATA_NULL;
            end
        endcase
    end

    assign bus.zero = ioe_is_zero(bus.result);

endmodule // ioe_alu

`default_nettype wire

// >>> ioe_exec.sv
/*
 * Execution block for increment, increment-skip-if-zero, absolute jump and
 * inclusive OR. Holds the accumulator, the zero flag, the program counter
 * and the 128-byte register file.
 * Assumes instructions arrive decoded and synchronous to ref_clk; the
 * high-latch value is held stable by its owner while a jump is taken.
 */
`timescale 1ns/100ps
`default_nettype none

// Contract
// - result goes to accumulator or file by bit
// - increment file register, route, update zero flag
// - increment, route, skip next on zero, flags kept
// - jump loads literal and latch bits into PC
// - jump unconditional, two cycles, flags untouched
// - OR literal into accumulator, update zero flag
// - OR accumulator with file, route, update flag
// - zero-result status bit is provided
module ioe_exec
    import ioe_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       instr_valid,
    output logic            instr_ready,
    input  wire ioe_op_t    instr_op,
    input  wire ioe_addr_t  instr_addr,
    input  wire logic       instr_dest,
    input  wire ioe_lit_t   instr_lit,
    input  wire ioe_latch_t pc_high_latch,
    input  wire logic       load_en,
    input  wire ioe_addr_t  load_addr,
    input  wire ioe_data_t  load_data,
    input  wire ioe_addr_t  peek_addr,
    output ioe_data_t       peek_data,
    output ioe_data_t       accumulator,
    output logic            result_null_flag,
    output ioe_pc_t         program_counter,
    output logic            exec_done,
    output logic            skip_taken,
    output logic            file_wr_en,
    output ioe_addr_t       file_wr_addr,
    output ioe_data_t       file_wr_data
);

    // ============================================================
    // state
    ioe_state_t state_q;
    ioe_state_t state_d;
    ioe_data_t  acc_q;
    logic       zero_q;
    ioe_pc_t    pc_q;
    ioe_pc_t    pc_d;
    ioe_data_t  peek_q;
    logic       done_q;
    logic       skip_q;
    logic       wr_en_q;
    ioe_addr_t  wr_addr_q;
    ioe_data_t  wr_data_q;

    ioe_data_t  file_mem [`IOE_FILE_DEPTH];

    // ============================================================
    // decode of the accepted instruction
    logic take;
    logic is_jump;
    logic is_file_op;
    logic to_file;
    logic to_acc;
    logic flag_upd;
    logic skip;

    ioe_alu_if alu_bus ();

    ioe_alu u_alu (
        .bus (alu_bus.alu)
    );

    assign alu_bus.op      = instr_op;
    assign alu_bus.acc     = acc_q;
    assign alu_bus.operand = file_mem[instr_addr];
    assign alu_bus.literal = instr_lit[`IOE_BYTE_HI:0];

    // new work is refused while a jump or null slot occupies the cycle
    assign instr_ready = (state_q == IOE_ST_READY);
    assign take        = instr_valid && instr_ready;
    assign is_jump     = (instr_op == IOE_OP_ABS_JUMP);
    assign is_file_op  = ioe_uses_file(instr_op);

    assign to_file  = take && is_file_op && instr_dest;
    assign to_acc   = take && ((instr_op == IOE_OP_OR_LITERAL) ||
                               (is_file_op && !instr_dest));

    // the skipping increment leaves the flag alone, as does the jump
    assign flag_upd = take && ((instr_op == IOE_OP_INC_FILE) ||
                               (instr_op == IOE_OP_OR_LITERAL) ||
                               (instr_op == IOE_OP_OR_FILE));
    assign skip     = take && (instr_op == IOE_OP_INC_SKIP_ZERO) &&
                      alu_bus.zero;

    // ============================================================
    // sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            IOE_ST_READY: begin
                if (take && is_jump) begin
                    state_d = IOE_ST_JUMP;
                end else if (skip) begin
                    state_d = IOE_ST_NULL;
                end
            end
            IOE_ST_JUMP: begin
                state_d = IOE_ST_READY;
            end
            IOE_ST_NULL: begin
                state_d = IOE_ST_READY;
            end
            default: begin
                state_d = IOE_ST_READY;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= IOE_ST_READY;
        end else begin
            state_q <= state_d;
        end
    end

    // ============================================================
    // program counter
    always_comb begin
        pc_d = pc_q;
        case (state_q)
            IOE_ST_READY: begin
                if (take && is_jump) begin
                    pc_d = {pc_high_latch[`IOE_LATCH_HI:`IOE_LATCH_LO],
                            instr_lit};
                end else if (take) begin
                    pc_d = pc_q + `IOE_PC_STEP;
                end
            end
            IOE_ST_NULL: begin
                // stepping past the skipped word
                pc_d = pc_q + `IOE_PC_STEP;
            end
            IOE_ST_JUMP: begin
                // second jump cycle only refills; target already loaded
                pc_d = pc_q;
            end
            default: begin
                pc_d = pc_q;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_q <= `IOE_PC_RST;
        end else begin
            pc_q <= pc_d;
        end
    end

    // ============================================================
    // accumulator and zero flag
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_q <= `IOE_ACC_RST;
        end else if (to_acc) begin
            acc_q <= alu_bus.result;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            zero_q <= `IOE_ZERO_RST;
        end else if (flag_upd) begin
            zero_q <= alu_bus.zero;
        end
    end

    // ============================================================
    // register file; an instruction write beats a load to the same cycle
    always_ff @(posedge ref_clk) begin
        if (to_file) begin
            file_mem[instr_addr] <= alu_bus.result;
        end else if (load_en) begin
            file_mem[load_addr] <= load_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            peek_q <= `IOE_DATA_NULL;
        end else begin
            peek_q <= file_mem[peek_addr];
        end
    end

    // ============================================================
    // completion and write reporting
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            done_q <= 1'b0;
            skip_q <= 1'b0;
        end else begin
            done_q <= (take && !is_jump && !skip) ||
                      (state_q != IOE_ST_READY);
            skip_q <= skip;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_en_q   <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= `IOE_DATA_NULL;
        end else begin
            wr_en_q <= to_file;
            if (to_file) begin
                wr_addr_q <= instr_addr;
                wr_data_q <= alu_bus.result;
            end
        end
    end

    assign peek_data        = peek_q;
    assign accumulator      = acc_q;
    assign result_null_flag = zero_q;
    assign program_counter  = pc_q;
    assign exec_done        = done_q;
    assign skip_taken       = skip_q;
    assign file_wr_en       = wr_en_q;
    assign file_wr_addr     = wr_addr_q;
    assign file_wr_data     = wr_data_q;

endmodule // ioe_exec

`default_nettype wire

// >>> ioe_exec_checker.sv
/* Checker for ioe_exec, bound to every instance.
   Assumes one ref_clk domain and an active-low rst_b. */
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// checker
module ioe_exec_checker
    import ioe_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic       instr_valid,
    input wire logic       instr_ready,
    input wire ioe_op_t    instr_op,
    input wire ioe_addr_t  instr_addr,
    input wire logic       instr_dest,
    input wire ioe_lit_t   instr_lit,
    input wire ioe_latch_t pc_high_latch,
    input wire ioe_data_t  accumulator,
    input wire logic       result_null_flag,
    input wire ioe_pc_t    program_counter,
    input wire logic       exec_done,
    input wire logic       skip_taken,
    input wire logic       file_wr_en,
    input wire ioe_addr_t  file_wr_addr,
    input wire ioe_data_t  file_wr_data
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic      tk;
    logic      fop;
    ioe_pc_t   tgt;
    ioe_data_t orv;
    assign tk  = instr_valid && instr_ready;
    assign fop = instr_op inside {IOE_OP_INC_FILE, IOE_OP_INC_SKIP_ZERO,
                                  IOE_OP_OR_FILE};
    assign tgt = {pc_high_latch[`IOE_LATCH_HI:`IOE_LATCH_LO], instr_lit};
    assign orv = accumulator | instr_lit[`IOE_BYTE_HI:0];
    // one refused cycle, then ready again with the done pulse
    sequence s_refuse_one;
        !instr_ready ##1 (instr_ready && exec_done);
    endsequence
    AST_DEST_FILE: assert property (tk && fop && instr_dest |=>
        file_wr_en && file_wr_addr == $past(instr_addr))
        else $error("file write missing for file destination");
    AST_DEST_ACC: assert property (tk && fop && !instr_dest |=>
        !file_wr_en) else $error("file written for accumulator target");
    AST_JUMP_PC: assert property (tk && instr_op == IOE_OP_ABS_JUMP |=>
        program_counter == $past(tgt)) else $error("jump target wrong");
    AST_JUMP_TWO: assert property (tk && instr_op == IOE_OP_ABS_JUMP
        |=> s_refuse_one) else $error("jump not two cycles");
    AST_JUMP_FLAG: assert property (tk && instr_op == IOE_OP_ABS_JUMP
        |=> $stable(result_null_flag)) else $error("jump changed flag");
    AST_SKIP_FLAG: assert property (tk && instr_op == IOE_OP_INC_SKIP_ZERO
        |=> $stable(result_null_flag)) else $error("skip op changed flag");
    AST_SKIP_SLOT: assert property (skip_taken |-> s_refuse_one)
        else $error("null slot not taken after skip");
    AST_OR_LIT: assert property (tk && instr_op == IOE_OP_OR_LITERAL |=>
        accumulator == $past(orv)) else $error("literal OR wrong");
    AST_ZERO: assert property (tk && instr_op inside {IOE_OP_INC_FILE,
        IOE_OP_OR_LITERAL, IOE_OP_OR_FILE} |=> result_null_flag ==
        (file_wr_en ? file_wr_data == 8'h00 : accumulator == 8'h00))
        else $error("zero flag wrong");
endmodule // ioe_exec_checker
bind ioe_exec ioe_exec_checker u_chk (.ref_clk, .rst_b, .instr_valid,
    .instr_ready, .instr_op, .instr_addr, .instr_dest, .instr_lit,
    .pc_high_latch, .accumulator, .result_null_flag, .program_counter,
    .exec_done, .skip_taken, .file_wr_en, .file_wr_addr, .file_wr_data);
`default_nettype wire

// >>> ioe_tb.sv
/* Self-checking testbench for ioe_exec.
   Assumes file memory is preloaded through load_en before use. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ioe_pkg::*;
    logic       ref_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       instr_valid = 1'b0;
    logic       instr_ready;
    ioe_op_t    instr_op = IOE_OP_NULL_SLOT;
    ioe_addr_t  instr_addr = 7'h00;
    logic       instr_dest = 1'b0;
    ioe_lit_t   instr_lit = 11'h000;
    ioe_latch_t pc_high_latch = 5'h00;
    logic       load_en = 1'b0;
    ioe_addr_t  load_addr = 7'h00;
    ioe_data_t  load_data = 8'h00;
    ioe_addr_t  peek_addr = 7'h00;
    ioe_data_t  peek_data, accumulator, file_wr_data;
    logic       result_null_flag, exec_done, skip_taken, file_wr_en;
    ioe_pc_t    program_counter, p;
    ioe_addr_t  file_wr_addr;
    logic       rdy1, skp1, z;
    ioe_data_t  d;
    int         error_cnt = 0;
    int         n_compared = 0;
    always #4 ref_clk = ~ref_clk;
    ioe_exec DUT (.ref_clk, .rst_b, .instr_valid, .instr_ready, .instr_op,
        .instr_addr, .instr_dest, .instr_lit, .pc_high_latch, .load_en,
        .load_addr, .load_data, .peek_addr, .peek_data, .accumulator,
        .result_null_flag, .program_counter, .exec_done, .skip_taken,
        .file_wr_en, .file_wr_addr, .file_wr_data);
    // ============================================================
    // helpers
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [12:0] e, g);
        n_compared++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic load(input ioe_addr_t a, input ioe_data_t v);
        @(posedge ref_clk);
        load_en <= 1'b1;
        load_addr <= a;
        load_data <= v;
        @(posedge ref_clk);
        load_en <= 1'b0;
    endtask
    task automatic peek(input ioe_addr_t a);
        @(posedge ref_clk);
        peek_addr <= a;
        @(posedge ref_clk);
        #1 d = peek_data;
    endtask
    // returns in the done cycle; the first cycle after taking is captured
    task automatic run(input ioe_op_t op, input ioe_addr_t a,
                       input logic ds, input ioe_lit_t k);
        int n;
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_addr <= a;
        instr_dest <= ds;
        instr_lit <= k;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        #1 rdy1 = instr_ready;
        skp1 = skip_taken;
        n = 0;
        while (exec_done !== 1'b1) begin
            if (n++ == 4) begin
                error_cnt++;
                $display("ERROR exec_done expected 1 seen %b", exec_done);
                finish_test();
            end
            @(posedge ref_clk);
            #1;
        end
    endtask
    // ============================================================
    // scenarios
    task automatic t_or_lit();
        run(IOE_OP_OR_LITERAL, 7'h00, 1'b0, 11'h700);
        chk("acc", 13'h00, accumulator);
        chk("zero", 13'h1, result_null_flag);
        run(IOE_OP_OR_LITERAL, 7'h00, 1'b0, 11'h05A);
        chk("acc", 13'h5A, accumulator);
        chk("zero", 13'h0, result_null_flag);
        $display("test or_literal done");
    endtask
    task automatic t_inc();
        p = program_counter;
        load(7'h05, 8'hFF);
        run(IOE_OP_INC_FILE, 7'h05, 1'b1, 11'h000);
        chk("wr_en", 13'h1, file_wr_en);
        chk("wr_addr", 13'h05, file_wr_addr);
        chk("wr_data", 13'h00, file_wr_data);
        chk("zero", 13'h1, result_null_flag);
        chk("pc", p + 13'h1, program_counter);
        load(7'h06, 8'h41);
        run(IOE_OP_INC_FILE, 7'h06, 1'b0, 11'h000);
        chk("acc", 13'h42, accumulator);
        chk("zero", 13'h0, result_null_flag);
        peek(7'h06);
        chk("file", 13'h41, d);
        $display("test increment done");
    endtask
    task automatic t_skip();
        p = program_counter;
        load(7'h07, 8'hFF);
        run(IOE_OP_INC_SKIP_ZERO, 7'h07, 1'b1, 11'h000);
        chk("skip", 13'h1, skp1);
        chk("ready", 13'h0, rdy1);
        chk("pc", p + 13'h2, program_counter);
        chk("zero", 13'h0, result_null_flag);
        peek(7'h07);
        chk("file", 13'h00, d);
        p = program_counter;
        load(7'h08, 8'h10);
        run(IOE_OP_INC_SKIP_ZERO, 7'h08, 1'b0, 11'h000);
        chk("skip", 13'h0, skp1);
        chk("acc", 13'h11, accumulator);
        chk("pc", p + 13'h1, program_counter);
        $display("test skip done");
    endtask
    task automatic t_jump();
        // sampled off the edge so no update can race the read
        z = result_null_flag;
        @(posedge ref_clk);
        pc_high_latch <= 5'h18;
        run(IOE_OP_ABS_JUMP, 7'h00, 1'b0, 11'h7FF);
        chk("pc", 13'h1FFF, program_counter);
        chk("ready", 13'h0, rdy1);
        chk("zero", z, result_null_flag);
        @(posedge ref_clk);
        pc_high_latch <= 5'h07;
        run(IOE_OP_ABS_JUMP, 7'h00, 1'b0, 11'h2A5);
        chk("pc", 13'h02A5, program_counter);
        $display("test jump done");
    endtask
    task automatic t_or_file();
        // set the flag first so the OR below must really clear it
        load(7'h0A, 8'hFF);
        run(IOE_OP_INC_FILE, 7'h0A, 1'b1, 11'h000);
        chk("zero", 13'h1, result_null_flag);
        load(7'h09, 8'hA4);
        run(IOE_OP_OR_FILE, 7'h09, 1'b1, 11'h000);
        chk("wr_data", 13'hB5, file_wr_data);
        chk("acc", 13'h11, accumulator);
        chk("zero", 13'h0, result_null_flag);
        run(IOE_OP_OR_FILE, 7'h09, 1'b0, 11'h000);
        chk("acc", 13'hB5, accumulator);
        $display("test or_file done");
    endtask
    task automatic t_null();
        p = program_counter;
        d = accumulator;
        run(IOE_OP_NULL_SLOT, 7'h0B, 1'b1, 11'h0FF);
        chk("pc", p + 13'h1, program_counter);
        chk("wr_en", 13'h0, file_wr_en);
        chk("acc", d, accumulator);
        $display("test null_slot done");
    endtask
    // mid-run reset; the first instruction follows at the first edge
    task automatic t_reset();
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        #1;
        chk("acc", 13'h00, accumulator);
        chk("pc", 13'h0000, program_counter);
        chk("zero", 13'h0, result_null_flag);
        chk("ready", 13'h1, instr_ready);
        run(IOE_OP_OR_LITERAL, 7'h00, 1'b0, 11'h000);
        chk("acc", 13'h00, accumulator);
        chk("zero", 13'h1, result_null_flag);
        chk("pc", 13'h0001, program_counter);
        $display("test reset done");
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_or_lit();
        t_inc();
        t_skip();
        t_jump();
        t_or_file();
        t_null();
        t_reset();
        finish_test();
    end
endmodule // testbench
`default_nettype wire
